// file: snfi_top.v
`timescale 1ns/1ns
`include "snfi_consts.vh"
module snfi_top #(
    parameter       AW       = 21,
    parameter [7:0] MFR_ID   = 8'hA5, // arbitrary value
    parameter [7:0] DEV_TYPE = 8'h3C, // arbitrary value
    parameter [7:0] DEV_CAP  = 8'h15, // arbitrary value
    parameter [7:0] SIG_ID   = 8'h14  // arbitrary value
)(
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // serial link
    input  wire        sclk_i,
    input  wire        cs_n_i,
    input  wire        bidir_line_0_i,
    output reg         bidir_line_0_o,
    output wire        bidir_line_0_oe_o,
    input  wire        bidir_line_1_i,
    output reg         bidir_line_1_o,
    output wire        bidir_line_1_oe_o
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [5:0] S_CMD   = 6'b000001;
    localparam [5:0] S_ADDR  = 6'b000010;
    localparam [5:0] S_DUMMY = 6'b000100;
    localparam [5:0] S_DATA  = 6'b001000;
    localparam [5:0] S_WDATA = 6'b010000;
    localparam [5:0] S_IGN   = 6'b100000;
    localparam [2:0] E_IDLE  = 3'b001;
    localparam [2:0] E_RUN   = 3'b010;
    localparam [2:0] E_HOLD  = 3'b100;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [1:0]    sck_s, csn_s, d0_s, d1_s;
    reg           sck_d, csn_d;
    reg  [5:0]    st_q;
    reg  [7:0]    op_q, sh_q, wrb_q;
    reg  [3:0]    bc_q, nb_q, dc_q;
    reg  [2:0]    oc_q;
    reg  [1:0]    di_q;
    reg  [23:0]   addr_q;
    reg  [8:0]    pcnt_q;
    reg  [2:0]    e_q;
    reg  [1:0]    ph_q;
    reg  [AW-1:0] ebase_q, ecnt_q, elast_q;
    reg           erase_q, fail_q, wlat_q;
    reg  [3:0]    bp_q;
    reg  [7:0]    exp_q;
    reg  [15:0]   hold_q, ctrl_q;
    reg  [7:0]    sr, ld_byte;
    reg  [4:0]    plo, phi;
    reg           pon;
    reg  [23:0]   er_mask;
    wire [7:0]    mem_rd, pb_rd;

    // ----------------------------------------------------------------
    // pin synchronisers and edge finding
    // ----------------------------------------------------------------
    // two flops per pin; only the second stage is used
    always @(posedge clk_i) begin
        if (rst_i) begin
            sck_s <= 2'h0;
            csn_s <= 2'h3;
            d0_s  <= 2'h0;
            d1_s  <= 2'h0;
            sck_d <= 1'b0;
            csn_d <= 1'b1;
        end else begin
            sck_s <= {sck_s[0], sclk_i};
            csn_s <= {csn_s[0], cs_n_i};
            d0_s  <= {d0_s[0], bidir_line_0_i};
            d1_s  <= {d1_s[0], bidir_line_1_i};
            sck_d <= sck_s[1];
            csn_d <= csn_s[1];
        end
    end

    wire csn    = csn_s[1];
    wire rise   = sck_s[1] & ~sck_d;  // sample edge, modes 0 and 3
    wire fall   = ~sck_s[1] & sck_d;  // launch edge
    wire cs_end = csn & ~csn_d;
    wire busy   = ~e_q[0];

    // ----------------------------------------------------------------
    // shift-in datapath
    // ----------------------------------------------------------------
    wire dual_in  = (op_q == `SNFI_OP_READ2) && (st_q == S_ADDR);
    wire dual_out = (op_q == `SNFI_OP_READ2) ||
                    (op_q == `SNFI_OP_DREAD);
    wire [3:0] bc_n = bc_q + (dual_in ? 4'h2 : 4'h1);
    wire [7:0] sh_n = dual_in ? {sh_q[5:0], d1_s[1], d0_s[1]}
                              : {sh_q[6:0], d0_s[1]};       // msb first
    wire shift_on   = rise && (st_q != S_DATA) && (st_q != S_DUMMY);
    wire byte_done  = shift_on && (bc_n == 4'h8);
    wire [3:0] dmy_n = (op_q == `SNFI_OP_READ2) ? `SNFI_DUMMY_2IO
                                                : `SNFI_DUMMY_1;
    wire mem_src = (op_q == `SNFI_OP_READ) || (op_q == `SNFI_OP_FAST) ||
                   (op_q == `SNFI_OP_DREAD) || (op_q == `SNFI_OP_READ2) ||
                   (op_q == `SNFI_OP_SFDP);
    wire pb_we = byte_done && (st_q == S_WDATA) && (op_q == `SNFI_OP_PP);
    wire [7:0] pb_wa = addr_q[7:0] + pcnt_q[7:0];

    // select framing: active only while select is low
    always @(posedge clk_i) begin
        if (rst_i || csn) begin
            st_q   <= S_CMD;
            bc_q   <= 4'h0;
            nb_q   <= 4'h0;
            dc_q   <= 4'h0;
            oc_q   <= 3'h0;
            di_q   <= 2'h0;
            pcnt_q <= 9'h000;
            if (rst_i) begin
                op_q           <= 8'h00;
                sh_q           <= 8'h00;
                wrb_q          <= 8'h00;
                addr_q         <= 24'h000000;
                bidir_line_0_o <= 1'b0;
                bidir_line_1_o <= 1'b0;
            end
        end else begin
            // count bits and bytes for the whole-byte
            if (shift_on) begin
                sh_q <= sh_n;
                bc_q <= byte_done ? 4'h0 : bc_n;
            end
            if (byte_done) begin
                nb_q <= nb_q + {3'h0, nb_q != 4'hF};
                case (st_q)
                    S_CMD: begin
                        op_q <= sh_n;
                        if (busy && sh_n != `SNFI_OP_RDSR) begin
                            st_q <= S_IGN;
                        end else begin
                            case (sh_n)
                                `SNFI_OP_RDSR, `SNFI_OP_RDID:
                                    st_q <= S_DATA;
                                `SNFI_OP_READ, `SNFI_OP_FAST,
                                `SNFI_OP_DREAD, `SNFI_OP_READ2,
                                `SNFI_OP_PP, `SNFI_OP_SE,
                                `SNFI_OP_BE32, `SNFI_OP_BE64,
                                `SNFI_OP_SIG, `SNFI_OP_MDID,
                                `SNFI_OP_SFDP:
                                    st_q <= S_ADDR;
                                `SNFI_OP_WRSR:
                                    st_q <= S_WDATA;
                                default:
                                    st_q <= S_IGN;
                            endcase
                        end
                    end
                    S_ADDR: begin
                        addr_q <= {addr_q[15:0], sh_n};
                        if (nb_q == 4'h3) begin
                            case (op_q)
                                `SNFI_OP_READ, `SNFI_OP_SIG,
                                `SNFI_OP_MDID:
                                    st_q <= S_DATA;
                                `SNFI_OP_PP:
                                    st_q <= S_WDATA;
                                `SNFI_OP_SE, `SNFI_OP_BE32,
                                `SNFI_OP_BE64:
                                    st_q <= S_IGN;
                                default:
                                    st_q <= S_DUMMY;
                            endcase
                        end
                    end
                    S_WDATA: begin
                        if (op_q == `SNFI_OP_WRSR) begin
                            wrb_q <= sh_n;
                        end else if (pcnt_q != `SNFI_PAGE) begin
                            pcnt_q <= pcnt_q + 9'h001;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // dummy clocks before data
            if (rise && st_q == S_DUMMY) begin
                dc_q <= dc_q + 4'h1;
                if (dc_q + 4'h1 == dmy_n) begin
                    st_q <= S_DATA;
                end
            end
            // launch data on the falling edge
            if (fall && st_q == S_DATA) begin
                if (oc_q == 3'h0) begin
                    bidir_line_1_o <= ld_byte[7];
                    if (dual_out) begin
                        bidir_line_0_o <= ld_byte[6];
                        sh_q <= {ld_byte[5:0], 2'h0};
                        oc_q <= 3'h3;
                    end else begin
                        sh_q <= {ld_byte[6:0], 1'b0};
                        oc_q <= 3'h7;
                    end
                    di_q <= di_q + 2'h1;
                    if (mem_src) begin
                        addr_q <= addr_q + 24'h000001;
                    end
                end else begin
                    bidir_line_1_o <= sh_q[7];
                    if (dual_out) begin
                        bidir_line_0_o <= sh_q[6];
                        sh_q <= {sh_q[5:0], 2'h0};
                    end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                    end
                    oc_q <= oc_q - 3'h1;
                end
            end
        end
    end

    // drive only in the data phase
    assign bidir_line_1_oe_o = (st_q == S_DATA) && !csn;
    assign bidir_line_0_oe_o = (st_q == S_DATA) && !csn && dual_out;

    // ----------------------------------------------------------------
    // status and outgoing byte selection
    // ----------------------------------------------------------------
    // status byte
    always @* begin
        sr = 8'h00;
        sr[`SNFI_SR_BUSY] = busy;
        sr[`SNFI_SR_WLAT] = wlat_q;
        sr[`SNFI_SR_PROT +: 4] = bp_q;
    end

    // table word shifted down to the addressed byte
    wire [31:0] sfdp_sh = `SNFI_SFDP_SIG >> {addr_q[1:0], 3'h0};

    // byte source for the data phase
    always @* begin
        case (op_q)
            `SNFI_OP_RDSR:
                ld_byte = sr;
            `SNFI_OP_RDID: begin
                case (di_q)
                    2'h0:    ld_byte = MFR_ID;
                    2'h1:    ld_byte = DEV_TYPE;
                    2'h2:    ld_byte = DEV_CAP;
                    default: ld_byte = 8'h00;
                endcase
            end
            `SNFI_OP_SIG:
                ld_byte = SIG_ID;
            `SNFI_OP_MDID:
                ld_byte = (di_q[0] ^ addr_q[0]) ? SIG_ID : MFR_ID;
            `SNFI_OP_SFDP:
                ld_byte = (addr_q[23:2] == 22'h000000) ?
                          sfdp_sh[7:0] : `SNFI_SFDP_FILL;
            default:
                ld_byte = mem_rd;
        endcase
    end

    // ----------------------------------------------------------------
    // protection decode, 64K block units
    // ----------------------------------------------------------------
    always @* begin
        pon = 1'b1;
        phi = 5'h1F;
        plo = 5'h00;
        case (bp_q)
            4'h0: pon = 1'b0;
            4'h1: plo = 5'h1F;
            4'h2: plo = 5'h1E;
            4'h3: plo = 5'h1C;
            4'h4: plo = 5'h18;
            4'h5: plo = 5'h10;
            4'hA: phi = 5'h0F;
            4'hB: phi = 5'h17;
            4'hC: phi = 5'h1B;
            4'hD: phi = 5'h1D;
            4'hE: phi = 5'h1E;
            default: pon = 1'b1;
        endcase
    end

    wire prot_hit = pon && (addr_q[20:16] >= plo) && (addr_q[20:16] <= phi);

    // erase size
    always @* begin
        case (op_q)
            `SNFI_OP_SE:   er_mask = `SNFI_MASK_4K;
            `SNFI_OP_BE32: er_mask = `SNFI_MASK_32K;
            `SNFI_OP_BE64: er_mask = `SNFI_MASK_64K;
            default:       er_mask = `SNFI_MASK_CHIP;
        endcase
    end

    // ----------------------------------------------------------------
    // self-timed program / erase engine
    // ----------------------------------------------------------------
    wire cmd_ok = cs_end && (bc_q == 4'h0);
    wire can_wr = cmd_ok && wlat_q && !busy;
    wire is_er  = (op_q == `SNFI_OP_SE) || (op_q == `SNFI_OP_BE32) ||
                  (op_q == `SNFI_OP_BE64);
    wire [AW-1:0] eaddr = erase_q ? ebase_q + ecnt_q :
        {ebase_q[AW-1:8], ebase_q[7:0] + ecnt_q[7:0]};      // page wrap
    wire [7:0] wdat = erase_q ? `SNFI_ERASED : (mem_rd & pb_rd);
    wire mem_we = (e_q == E_RUN) && (ph_q == 2'h1);
    wire [23:0] er_base = addr_q & ~er_mask;

    always @(posedge clk_i) begin
        if (rst_i) begin
            e_q     <= E_IDLE;
            ph_q    <= 2'h0;
            ebase_q <= {AW{1'b0}};
            ecnt_q  <= {AW{1'b0}};
            elast_q <= {AW{1'b0}};
            erase_q <= 1'b0;
            fail_q  <= 1'b0;
            wlat_q  <= 1'b0;
            bp_q    <= 4'h0;
            exp_q   <= 8'h00;
            hold_q  <= 16'h0000;
        end else begin
            case (e_q)
                E_RUN: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h1) begin
                        exp_q <= wdat;
                    end
                    if (ph_q == 2'h3) begin
                        if (mem_rd != exp_q) begin
                            fail_q <= 1'b1;                 // verify
                        end
                        if (ecnt_q == elast_q) begin
                            e_q    <= E_HOLD;
                            hold_q <= ctrl_q;
                        end else begin
                            ecnt_q <= ecnt_q + {{(AW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                E_HOLD: begin
                    if (hold_q == 16'h0000) begin
                        e_q    <= E_IDLE;
                        wlat_q <= 1'b0;
                    end else begin
                        hold_q <= hold_q - 16'h0001;
                    end
                end
                default: begin
                end
            endcase
            // commands executed at the end of the frame
            if (cmd_ok && op_q == `SNFI_OP_WRDI && nb_q == 4'h1) begin
                wlat_q <= 1'b0;
            end
            if (can_wr && op_q == `SNFI_OP_WRSR && nb_q == 4'h2) begin
                bp_q   <= wrb_q[`SNFI_SR_PROT +: 4];
                wlat_q <= 1'b0;
            end
            if (can_wr && ((is_er && nb_q == 4'h4 && !prot_hit) ||
                (op_q == `SNFI_OP_CE && nb_q == 4'h1 && bp_q == 4'h0))) begin
                e_q     <= E_RUN;
                erase_q <= 1'b1;
                ebase_q <= er_base[AW-1:0];
                elast_q <= er_mask[AW-1:0];
                ecnt_q  <= {AW{1'b0}};
                ph_q    <= 2'h0;
                fail_q  <= 1'b0;
            end
            if (can_wr && op_q == `SNFI_OP_PP && nb_q >= 4'h5 &&
                pcnt_q != 9'h000 && !prot_hit) begin
                e_q     <= E_RUN;
                erase_q <= 1'b0;
                ebase_q <= addr_q[AW-1:0];
                elast_q <= {{(AW-9){1'b0}}, pcnt_q - 9'h001};
                ecnt_q  <= {AW{1'b0}};
                ph_q    <= 2'h0;
                fail_q  <= 1'b0;
            end
            // set wins over a clear in the same cycle
            if (cmd_ok && op_q == `SNFI_OP_WR_EN && nb_q == 4'h1) begin
                wlat_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // array and page buffer
    // ----------------------------------------------------------------
    snfi_mem #(.AW(AW), .DW(8)) u_array (
        .clk_i (clk_i),
        .we_i  (mem_we),
        .wa_i  (eaddr),
        .wd_i  (wdat),
        .ra_i  (busy ? eaddr : addr_q[AW-1:0]),
        .rd_o  (mem_rd)
    );

    snfi_mem #(.AW(8), .DW(8)) u_page (
        .clk_i (clk_i),
        .we_i  (pb_we),
        .wa_i  (pb_wa),
        .wd_i  (sh_n),
        .ra_i  (eaddr[7:0]),
        .rd_o  (pb_rd)
    );

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // single-wait ack, registered read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_q   <= `SNFI_HOLD_RST;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                if (wb_we_i && wb_adr_i[3:2] == `SNFI_WB_CTRL) begin
                    if (wb_sel_i[0]) begin
                        ctrl_q[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        ctrl_q[15:8] <= wb_dat_i[15:8];
                    end
                end
                case (wb_adr_i[3:2])
                    `SNFI_WB_STATUS: wb_dat_o <= {23'h000000, fail_q, sr};
                    `SNFI_WB_CTRL:   wb_dat_o <= {16'h0000, ctrl_q};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// file: snfi_consts.vh
// What this block does
// - Accept SPI clock mode 0 and mode 3; host uses one of them.
// - Single-line uses clock, data in, data out; active only while select low.
// - Dual-line read takes address and dummy on both lines, returns both.
// - Single-line fast read has 8 dummy clocks; 104MHz or 50MHz clock.
// - Single-in dual-out fast read has 8 dummy clocks, two bits per clock.
// - Program a single byte, a word or a page up to 256 bytes.
// - Erase a 4K sector, 32K block, 64K block or the whole array.
// - Accepted program or erase runs self-timed, performs then verifies.
// - Status shows busy flag during program or erase; host polls it.
// - Identification read returns one maker byte then two device bytes.
// - Signature command returns one device identification byte.
// - Maker-device command returns one maker byte and one device byte.
// - Four block-protect bits select the region shielded from changes.
// - Reads continue through consecutive addresses across the whole array.
// - Array is 2,097,152 locations of eight bits.
// - Discoverable-parameter read returns a capability table; here only the SFDP signature word, then FF.
// - Write enable sets the latch; data changes refused while it is clear.
// - Whole-array erase accepted only with all protect bits zero.
// - Commands not ending on a whole byte are discarded.
`ifndef SNFI_CONSTS_VH
`define SNFI_CONSTS_VH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SNFI_OP_WR_EN  8'h06
`define SNFI_OP_WRDI   8'h04
`define SNFI_OP_RDSR   8'h05
`define SNFI_OP_WRSR   8'h01
`define SNFI_OP_READ   8'h03
`define SNFI_OP_FAST   8'h0B
`define SNFI_OP_DREAD  8'h3B
`define SNFI_OP_READ2  8'hBB
`define SNFI_OP_PP     8'h02
`define SNFI_OP_SE     8'h20
`define SNFI_OP_BE32   8'h52
`define SNFI_OP_BE64   8'hD8
`define SNFI_OP_CE     8'hC7
`define SNFI_OP_RDID   8'h9F
`define SNFI_OP_SIG    8'hAB
`define SNFI_OP_MDID   8'h90
`define SNFI_OP_SFDP   8'h5A

// ----------------------------------------------------------------
// status fields, counts, sizes
// ----------------------------------------------------------------
`define SNFI_SR_BUSY   0
`define SNFI_SR_WLAT   1
`define SNFI_SR_PROT   2
`define SNFI_DUMMY_1   4'h8
`define SNFI_DUMMY_2IO 4'h4
`define SNFI_PAGE      9'h100
`define SNFI_MASK_4K   24'h000FFF
`define SNFI_MASK_32K  24'h007FFF
`define SNFI_MASK_64K  24'h00FFFF
`define SNFI_MASK_CHIP 24'hFFFFFF
`define SNFI_ERASED    8'hFF
`define SNFI_SFDP_SIG  32'h50444653
`define SNFI_SFDP_FILL 8'hFF

// ----------------------------------------------------------------
// wishbone register map (word index = adr[3:2]) and resets
// ----------------------------------------------------------------
`define SNFI_WB_STATUS 2'h0
`define SNFI_WB_CTRL   2'h1
`define SNFI_HOLD_RST  16'h0010

`endif

// file: snfi_mem.v
`timescale 1ns/1ns
// ----------------------------------------------------------------
// simple dual port memory, registered read data
// ----------------------------------------------------------------
module snfi_mem #(
    parameter AW = 21,
    parameter DW = 8
)(
    // clock
    input  wire          clk_i,
    // write port
    input  wire          we_i,
    input  wire [AW-1:0] wa_i,
    input  wire [DW-1:0] wd_i,
    // read port
    input  wire [AW-1:0] ra_i,
    output reg  [DW-1:0] rd_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer k;

    // start out in the erased state
    initial begin
        for (k = 0; k < (1<<AW); k = k + 1) begin
            mem[k] = {DW{1'b1}};
        end
        rd_o = {DW{1'b1}};
    end

    // write then registered read
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[wa_i] <= wd_i;
        end
        rd_o <= mem[ra_i];
    end
endmodule

// file: snfi_properties.sv
`timescale 1ns/1ns
// bus answers and pin drive of the top
module snfi_props(
    input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire        sclk_i, cs_n_i, bidir_line_0_o, bidir_line_1_o,
    input wire        bidir_line_0_oe_o, bidir_line_1_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_DAT_HOLD: assert property (!$stable(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved");
    AST_OE_IDLE: assert property (cs_n_i [*6]
        |-> !bidir_line_1_oe_o) else $error("drive while idle");
    AST_OE_SEL: assert property ($rose(bidir_line_1_oe_o)
        |-> !cs_n_i) else $error("drive unselected");
    AST_DUAL_OE: assert property (bidir_line_0_oe_o
        |-> bidir_line_1_oe_o) else $error("dual drive alone");
    AST_OUT_LOW: assert property (!$stable(bidir_line_1_o)
        |-> !sclk_i) else $error("output moved clock high");
    AST_DUAL_LOW: assert property (bidir_line_0_oe_o &&
        !$stable(bidir_line_0_o) |-> !sclk_i) else $error("dual moved");
    // main scenarios
    cover property (wb_ack_o && wb_cyc_i);
    cover property ($rose(bidir_line_0_oe_o));
    cover property ($rose(bidir_line_1_oe_o));
endmodule
bind snfi_top snfi_props snfi_props_inst(.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_dat_o, .sclk_i, .cs_n_i, .bidir_line_0_o,
    .bidir_line_1_o, .bidir_line_0_oe_o, .bidir_line_1_oe_o);

// file: snfi_host.sv
`timescale 1ns/1ns
// host controller: mode 0 or mode 3 clock, select, data on line 0
module snfi_host(
    input  wire clk_i, l0_i, l1_i,
    output reg  sclk_o = 1'b0, cs_n_o = 1'b1, d0_o = 1'b0, d1_o = 1'b0
);
    // line 1 carries no host data: drive it toggling every clock
    always @(posedge clk_i) d1_o <= ~d1_o;
    // park the clock high before a mode 3 frame
    task hi;
        begin @(posedge clk_i); sclk_o <= 1'b1; end
    endtask
    task go;
        begin @(posedge clk_i); cs_n_o <= 1'b0; end
    endtask
    // last fall, then select high with the clock low
    task stop;
        begin
            @(posedge clk_i); sclk_o <= 1'b0;
            repeat (5) @(posedge clk_i);
            cs_n_o <= 1'b1;
            repeat (12) @(posedge clk_i);
        end
    endtask
    // n clocks, msb first; d takes two bits per clock
    task xb(input [7:0] t, input integer n, input d, output [7:0] r);
        integer i;
        begin
            r = 8'h00;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk_i); sclk_o <= 1'b0; d0_o <= t[7-i];
                repeat (5) @(posedge clk_i);
                sclk_o <= 1'b1;
                r = d ? {r[5:0], l1_i, l0_i} : {r[6:0], l1_i};
                repeat (4) @(posedge clk_i);
            end
        end
    endtask
endmodule

// file: tb_serial_nor_flash_interface.sv
`timescale 1ns/1ns
module tb_serial_nor_flash_interface;
    reg         clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
    reg  [3:0]  adr = 4'h0;
    reg  [31:0] wd = 32'h0, rd;
    reg  [7:0]  b;
    integer     n_fail = 0, samples_checked = 0, k;
    wire [31:0] dat;
    wire        ack, sc, cs, h0, h1, o0, o1, e0, e1;
    wire        l0 = e0 ? o0 : h0;
    wire        l1 = e1 ? o1 : h1;
    always #4 clk = ~clk;
    snfi_top #(.AW(17)) snfi_top_inst(.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
        .sclk_i(sc), .cs_n_i(cs), .bidir_line_0_i(l0),
        .bidir_line_0_o(o0), .bidir_line_0_oe_o(e0), .bidir_line_1_i(l1),
        .bidir_line_1_o(o1), .bidir_line_1_oe_o(e1));
    snfi_host snfi_host_inst(.clk_i(clk), .l0_i(l0), .l1_i(l1),
        .sclk_o(sc), .cs_n_o(cs), .d0_o(h0), .d1_o(h1));
    task conclude;
        begin
            if (n_fail == 0 && samples_checked > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [31:0] e, g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // one classic cycle, held until ack is sampled
    task wb(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk); cyc <= 1'b1; we <= w; adr <= a; wd <= d;
            @(posedge clk);
            while (ack !== 1'b1) @(posedge clk);
            rd = dat; cyc <= 1'b0;
        end
    endtask
    task st(input [31:0] e); begin wb(0, 0, 0); chk("status", e, rd); end
    endtask
    task idle; begin wb(0, 0, 0); repeat (9999) if (rd[0] !== 1'b0) wb(0, 0, 0);
        chk("busy", 0, rd[0]); end
    endtask
    // frame helpers
    task fr(input [7:0] op, input [23:0] a, input integer na);
        begin
            snfi_host_inst.go; snfi_host_inst.xb(op, 8, 0, b);
            for (k = 0; k < na; k = k + 1)
                snfi_host_inst.xb(a[23-8*k -: 8], 8, 0, b);
        end
    endtask
    task tx(input [7:0] d); snfi_host_inst.xb(d, 8, 0, b); endtask
    task sp; snfi_host_inst.stop; endtask
    task ex(input [7:0] op); begin fr(op, 0, 0); sp; end endtask
    task rx(input d, input [7:0] e);
        begin snfi_host_inst.xb(0, d ? 4 : 8, d, b); chk("link", e, b); end
    endtask
    // scenarios
    task t_regs; begin
        st(0); wb(1, 4'h4, 0); chk("ctrl", 32'h10, rd);
        wb(1, 4'h0, 32'hFF); wb(1, 4'h8, 32'hFF); st(0);
        wb(0, 4'h8, 0); chk("unmapped", 0, rd);
        wb(1, 4'h4, 32'h400); wb(0, 4'h4, 0); chk("ctrl", 32'h400, rd); end
    endtask
    task t_id; begin
        fr(8'h9F, 0, 0); rx(0, 8'hA5); rx(0, 8'h3C); rx(0, 8'h15); sp;
        snfi_host_inst.hi;
        fr(8'hAB, 0, 3); rx(0, 8'h14); sp;
        fr(8'h90, 0, 3); rx(0, 8'hA5); sp;
        fr(8'h5A, 0, 3); tx(0); rx(0, 8'h53); rx(0, 8'h46);
        rx(0, 8'h44); rx(0, 8'h50); sp; end
    endtask
    task t_prog; begin
        ex(8'h06); st(2); fr(8'h02, 24'hFE, 3);
        tx(8'h12); tx(8'h34); tx(8'h56); sp; st(3);
        fr(8'h05, 0, 0); rx(0, 8'h03); sp;
        fr(8'h01, 0, 0); tx(8'h3C); sp; idle; st(0);
        fr(8'h03, 24'hFE, 3); rx(0, 8'h12); rx(0, 8'h34); rx(0, 8'hFF); sp;
        fr(8'h03, 0, 3); rx(0, 8'h56); sp; end
    endtask
    task t_fast; begin
        fr(8'h0B, 24'hFE, 3); tx(0); rx(0, 8'h12); sp;
        fr(8'h3B, 24'hFE, 3); tx(0); rx(1, 8'h12); rx(1, 8'h34); sp; end
    endtask
    task t_refuse; begin
        fr(8'h02, 24'h200, 3); tx(0); sp;
        fr(8'h03, 24'h200, 3); rx(0, 8'hFF); sp;
        ex(8'h06); ex(8'h04); st(0);
        fr(8'h06, 0, 0); snfi_host_inst.xb(0, 1, 0, b); sp; st(0); end
    endtask
    task t_erase; begin
        ex(8'h06); fr(8'h20, 24'h10, 3); sp; idle;
        fr(8'h03, 24'hFE, 3); rx(0, 8'hFF); sp; end
    endtask
    task t_prot; begin
        ex(8'h06); fr(8'h01, 0, 0); tx(8'h04); sp; idle;
        chk("protect", 1, rd[5:2]);
        ex(8'h06); fr(8'hD8, 24'h1F0000, 3); sp; st(6);
        ex(8'hC7); st(6); end
    endtask
    task t_rst; begin
        rst <= 1'b1; repeat (3) @(posedge clk); rst <= 1'b0;
        repeat (4) @(posedge clk); st(0); wb(0, 4'h4, 0);
        chk("ctrl", 32'h10, rd); end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_regs; t_id; t_prog; t_fast; t_refuse; t_erase; t_prot; t_rst;
        conclude;
    end
    // watchdog
    initial begin #480000; n_fail = n_fail + 1; conclude; end
endmodule
